// ===== src/aor_pkg.sv
// Behaviour
// - Two-bit rate divider field in rate register.
// - Divider codes: full, half, quarter, eighth rate.
// - Full rate by default and with test patterns.
// - Decimate-by-two takes one code per two samples and sends it twice.
// - Sync pulse resets decimation dividers, aligning channels.
// - Pin sync works after reset, no writes needed.
// - Sync never alters the sampling instants.
// - Hard sync aligns ramps, disables filter sync.
// - Offset binary default; twos-complement inverts MSB.
// - LSB first by default; option sends MSB first.
// - Sixteen lanes, two groups of eight.
// - Per-lane four-bit fields route group inputs.
// - Lower codes: pairs per input, bit3 powers down.
// - Upper codes select inputs eight down to five.
`default_nettype none
package aor_pkg;
    localparam int CHANNELS  = 8;
    localparam int LANES     = 16;
    localparam int RES       = 14;
    localparam int AXI_AW    = 12;
    localparam logic [3:0] WORD_BITS = 4'he;
    localparam logic [3:0] BYTE_BITS = 4'h7;

    localparam logic [7:0] IDX_SYNC_ENABLE = 8'h02;
    localparam logic [7:0] IDX_HARD_SYNC   = 8'h25;
    localparam logic [7:0] IDX_RATE        = 8'h38;
    localparam logic [7:0] IDX_CTRL        = 8'h3a;
    localparam logic [7:0] IDX_STATUS      = 8'h3b;
    localparam logic [7:0] IDX_FORMAT      = 8'h46;
    localparam logic [7:0] IDX_MAP_LO0     = 8'h50;
    localparam logic [7:0] IDX_MAP_LO1     = 8'h51;
    localparam logic [7:0] IDX_MAP_LO2     = 8'h52;
    localparam logic [7:0] IDX_MAP_UP0     = 8'h53;
    localparam logic [7:0] IDX_MAP_UP1     = 8'h54;
    localparam logic [7:0] IDX_MAP_UP2     = 8'h55;

    localparam int SYNC_EN_BIT    = 13;
    localparam int HARD_SYNC_BIT  = 15;
    localparam int BTC_BIT        = 2;
    localparam int MSB_FIRST_BIT  = 3;
    localparam int CTRL_DECIM_BIT = 0;
    localparam int CTRL_2WIRE_BIT = 1;
    localparam int CTRL_TEST_BIT  = 2;
    localparam int MAP_OFF_BIT    = 3;

    localparam logic [1:0]  RST_RATE    = 2'h0;
    localparam logic [2:0]  RST_CTRL    = 3'h0;
    localparam logic [11:0] RST_MAP_LO0 = 12'h210;
    localparam logic [11:0] RST_MAP_LO1 = 12'h543;
    localparam logic [11:0] RST_MAP_LO2 = 12'h076;
    localparam logic [11:0] RST_MAP_UP0 = 12'h567;
    localparam logic [11:0] RST_MAP_UP1 = 12'h234;
    localparam logic [11:0] RST_MAP_UP2 = 12'h001;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic                              valid;
        logic [CHANNELS-1:0][RES-1:0]      code;
    } aor_sample_t;

    typedef struct packed {
        logic [LANES-1:0] data;
        logic [LANES-1:0] active;
        logic [LANES-1:0] frame;
    } aor_lane_t;
endpackage
`default_nettype wire

// ===== src/aor_lane_ser.sv
`timescale 1ns/1ps
`default_nettype none
module aor_lane_ser (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        load,
    input  wire logic [13:0] word,
    input  wire logic [3:0]  nbits,
    input  wire logic        msb_first,
    input  wire logic        enable,
    output logic             ser_bit,
    output logic             ser_active,
    output logic             ser_frame
);
    typedef struct packed {
        logic [13:0] sh;
        logic [3:0]  cnt;
        logic [3:0]  nb;
        logic        act;
        logic        bit_o;
        logic        frm;
    } aor_ser_state_t;

    aor_ser_state_t st_ff;
    aor_ser_state_t nxt_st;

    function automatic logic [13:0] rev14(input logic [13:0] v);
        logic [13:0] r;
        r = '0;
        for (int i = 0; i < 14; i++) begin
            r[13-i] = v[i];
        end
        return r;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.bit_o = 1'b0;
        nxt_st.frm = 1'b0;
        if (load) begin
            if (msb_first) begin
                nxt_st.sh = (nbits == aor_pkg::BYTE_BITS) ?
                            (rev14(word) >> 7) : rev14(word);
            end else begin
                nxt_st.sh = word;
            end
            nxt_st.cnt = nbits;
            nxt_st.nb = nbits;
            nxt_st.act = enable;
        end else if (st_ff.cnt != 4'h0) begin
            nxt_st.bit_o = st_ff.act & st_ff.sh[0];
            nxt_st.frm = st_ff.act & (st_ff.cnt == st_ff.nb);
            nxt_st.sh = st_ff.sh >> 1;
            nxt_st.cnt = st_ff.cnt - 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ser_bit    = st_ff.bit_o;
    assign ser_active = st_ff.act;
    assign ser_frame  = st_ff.frm;
endmodule
`default_nettype wire

// ===== src/aor_top.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module aor_top (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    input  wire logic [aor_pkg::AXI_AW-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [aor_pkg::AXI_AW-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire aor_pkg::aor_sample_t        sample,
    input  wire logic                        sync_pin,
    output aor_pkg::aor_lane_t               lanes
);
    typedef struct packed {
        logic [2:0]                      sync_sh;
        logic                            sync_lvl;
        logic                            aw_full;
        logic [7:0]                      aw_idx;
        logic                            aw_bad;
        logic                            w_full;
        logic [31:0]                     w_data;
        logic [3:0]                      w_strb;
        logic                            b_valid;
        logic [1:0]                      b_resp;
        logic                            r_valid;
        logic [31:0]                     r_data;
        logic [1:0]                      r_resp;
        logic                            sync_en;
        logic                            hard_sync;
        logic [1:0]                      rate;
        logic                            btc;
        logic                            msb_first;
        logic [2:0]                      ctrl;
        logic [5:0][11:0]                map;
        logic [aor_pkg::CHANNELS-1:0]    phase;
        logic [aor_pkg::CHANNELS-1:0][aor_pkg::RES-1:0] ramp;
        logic [aor_pkg::CHANNELS-1:0][aor_pkg::RES-1:0] held;
        logic [2:0]                      rate_cnt;
        logic                            load;
    } aor_state_t;

    aor_state_t st_ff;
    aor_state_t nxt_st;

    logic                        sync_edge;
    logic [31:0]                 cur_word;
    logic [15:0]                 wr_val;
    logic [2:0]                  rate_mask;
    logic [aor_pkg::RES-1:0]     in_code;
    logic [31:0]                 lower_flat;
    logic [31:0]                 upper_flat;
    logic [aor_pkg::LANES-1:0]   lane_bit;
    logic [aor_pkg::LANES-1:0]   lane_act;
    logic [aor_pkg::LANES-1:0]   lane_frm;
    logic                        two_wire;
    logic                        test_on;
    logic                        decim_on;

    // Returns true for an address that lands on a mapped register.
    function automatic logic addr_hit(input logic [aor_pkg::AXI_AW-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[aor_pkg::AXI_AW-1:10] != '0) begin
            return 1'b0;
        end
        return (idx == aor_pkg::IDX_SYNC_ENABLE) ||
               (idx == aor_pkg::IDX_HARD_SYNC) ||
               (idx == aor_pkg::IDX_RATE) ||
               (idx == aor_pkg::IDX_CTRL) ||
               (idx == aor_pkg::IDX_STATUS) ||
               (idx == aor_pkg::IDX_FORMAT) ||
               (idx >= aor_pkg::IDX_MAP_LO0 && idx <= aor_pkg::IDX_MAP_UP2);
    endfunction

    // Read view of every register; unmapped indices read as zero.
    function automatic logic [31:0] rd_word(input aor_state_t s,
                                            input logic [7:0] idx);
        logic [31:0] r;
        r = '0;
        unique case (idx)
            aor_pkg::IDX_SYNC_ENABLE: r[aor_pkg::SYNC_EN_BIT] = s.sync_en;
            aor_pkg::IDX_HARD_SYNC: r[aor_pkg::HARD_SYNC_BIT] = s.hard_sync;
            aor_pkg::IDX_RATE: r[1:0] = s.rate;
            aor_pkg::IDX_CTRL: r[2:0] = s.ctrl;
            aor_pkg::IDX_STATUS: r[8:0] = {s.sync_lvl, s.phase};
            aor_pkg::IDX_FORMAT: begin
                r[aor_pkg::BTC_BIT] = s.btc;
                r[aor_pkg::MSB_FIRST_BIT] = s.msb_first;
            end
            aor_pkg::IDX_MAP_LO0: r[11:0] = s.map[0];
            aor_pkg::IDX_MAP_LO1: r[11:0] = s.map[1];
            aor_pkg::IDX_MAP_LO2: r[7:0] = s.map[2][7:0];
            aor_pkg::IDX_MAP_UP0: r[11:0] = s.map[3];
            aor_pkg::IDX_MAP_UP1: r[11:0] = s.map[4];
            aor_pkg::IDX_MAP_UP2: r[7:0] = s.map[5][7:0];
            default: r = '0;
        endcase
        return r;
    endfunction

    // Merges written byte lanes into the current low half-word.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] strb);
        return {strb[1] ? d[15:8] : old[15:8],
                strb[0] ? d[7:0] : old[7:0]};
    endfunction

    assign two_wire = st_ff.ctrl[aor_pkg::CTRL_2WIRE_BIT];
    assign test_on  = st_ff.ctrl[aor_pkg::CTRL_TEST_BIT];
    assign decim_on = st_ff.ctrl[aor_pkg::CTRL_DECIM_BIT];

    assign s_axi_awready = !st_ff.aw_full && !st_ff.b_valid;
    assign s_axi_wready  = !st_ff.w_full && !st_ff.b_valid;
    assign s_axi_arready = !st_ff.r_valid;
    assign s_axi_bvalid  = st_ff.b_valid;
    assign s_axi_bresp   = st_ff.b_resp;
    assign s_axi_rvalid  = st_ff.r_valid;
    assign s_axi_rdata   = st_ff.r_data;
    assign s_axi_rresp   = st_ff.r_resp;

    // A rise of the pin level counts once the last two stages agree.
    assign sync_edge = (st_ff.sync_sh[1] == st_ff.sync_sh[2]) &&
                       st_ff.sync_sh[1] && !st_ff.sync_lvl;

    always_comb begin
        unique case (st_ff.rate)
            2'h0: rate_mask = 3'h0;
            2'h1: rate_mask = 3'h1;
            2'h2: rate_mask = 3'h3;
            2'h3: rate_mask = 3'h7;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.load = 1'b0;
        in_code = '0;
        cur_word = rd_word(st_ff, st_ff.aw_idx);
        wr_val = merge16(cur_word[15:0], st_ff.w_data, st_ff.w_strb);

        nxt_st.sync_sh = {st_ff.sync_sh[1:0], sync_pin};
        if (st_ff.sync_sh[1] == st_ff.sync_sh[2]) begin
            nxt_st.sync_lvl = st_ff.sync_sh[1];
        end

        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_full = 1'b1;
            nxt_st.aw_idx = s_axi_awaddr[9:2];
            nxt_st.aw_bad = !addr_hit(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_full = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end
        if (st_ff.aw_full && st_ff.w_full) begin
            nxt_st.aw_full = 1'b0;
            nxt_st.w_full = 1'b0;
            nxt_st.b_valid = 1'b1;
            nxt_st.b_resp = st_ff.aw_bad ? aor_pkg::RESP_SLVERR
                                         : aor_pkg::RESP_OKAY;
            if (!st_ff.aw_bad) begin
                unique case (st_ff.aw_idx)
                    aor_pkg::IDX_SYNC_ENABLE:
                        nxt_st.sync_en = wr_val[aor_pkg::SYNC_EN_BIT];
                    aor_pkg::IDX_HARD_SYNC:
                        nxt_st.hard_sync = wr_val[aor_pkg::HARD_SYNC_BIT];
                    aor_pkg::IDX_RATE: nxt_st.rate = wr_val[1:0];
                    aor_pkg::IDX_CTRL: nxt_st.ctrl = wr_val[2:0];
                    aor_pkg::IDX_FORMAT: begin
                        nxt_st.btc = wr_val[aor_pkg::BTC_BIT];
                        nxt_st.msb_first = wr_val[aor_pkg::MSB_FIRST_BIT];
                    end
                    aor_pkg::IDX_MAP_LO0: nxt_st.map[0] = wr_val[11:0];
                    aor_pkg::IDX_MAP_LO1: nxt_st.map[1] = wr_val[11:0];
                    aor_pkg::IDX_MAP_LO2: nxt_st.map[2] = {4'h0, wr_val[7:0]};
                    aor_pkg::IDX_MAP_UP0: nxt_st.map[3] = wr_val[11:0];
                    aor_pkg::IDX_MAP_UP1: nxt_st.map[4] = wr_val[11:0];
                    aor_pkg::IDX_MAP_UP2: nxt_st.map[5] = {4'h0, wr_val[7:0]};
                    default: nxt_st.b_resp = aor_pkg::RESP_OKAY;
                endcase
            end
        end
        if (st_ff.b_valid && s_axi_bready) begin
            nxt_st.b_valid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_st.r_valid = 1'b1;
            nxt_st.r_data = rd_word(st_ff, s_axi_araddr[9:2]);
            nxt_st.r_resp = addr_hit(s_axi_araddr) ? aor_pkg::RESP_OKAY
                                                   : aor_pkg::RESP_SLVERR;
        end
        if (st_ff.r_valid && s_axi_rready) begin
            nxt_st.r_valid = 1'b0;
        end

        // Every sample is taken on its own strobe; sync only clears phases and rate count, or with hard sync the ramps.
        if (sample.valid) begin
            for (int ch = 0; ch < aor_pkg::CHANNELS; ch++) begin
                in_code = test_on ? st_ff.ramp[ch] : sample.code[ch];
                nxt_st.ramp[ch] = st_ff.ramp[ch] + 14'h0001;
                if (!decim_on || !st_ff.phase[ch]) begin
                    nxt_st.held[ch] = in_code;
                end
                if (decim_on) begin
                    nxt_st.phase[ch] = !st_ff.phase[ch];
                end
            end
            nxt_st.rate_cnt = st_ff.rate_cnt + 3'h1;
            // Test patterns always leave at the sampling rate.
            nxt_st.load = test_on ||
                          ((st_ff.rate_cnt & rate_mask) == 3'h0);
        end

        if (sync_edge) begin
            if (st_ff.hard_sync) begin
                for (int ch = 0; ch < aor_pkg::CHANNELS; ch++) begin
                    nxt_st.ramp[ch] = '0;
                end
            end else begin
                nxt_st.phase = '0;
                nxt_st.rate_cnt = 3'h0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.rate <= aor_pkg::RST_RATE;
            st_ff.ctrl <= aor_pkg::RST_CTRL;
            st_ff.map <= {aor_pkg::RST_MAP_UP2, aor_pkg::RST_MAP_UP1,
                          aor_pkg::RST_MAP_UP0, aor_pkg::RST_MAP_LO2,
                          aor_pkg::RST_MAP_LO1, aor_pkg::RST_MAP_LO0};
            for (int ch = 0; ch < aor_pkg::CHANNELS; ch++) begin
                st_ff.phase[ch] <= ch[0];
                st_ff.ramp[ch] <= ch[aor_pkg::RES-1:0];
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lower_flat = {st_ff.map[2][7:0], st_ff.map[1], st_ff.map[0]};
    assign upper_flat = {st_ff.map[5][7:0], st_ff.map[4], st_ff.map[3]};

    // Lanes 0..7 are 1A,1B..4A,4B; lanes 8..15 are 5A,5B..8A,8B.
    for (genvar gl = 0; gl < aor_pkg::LANES; gl++) begin : g_lane
        localparam int LI = gl % 8;
        localparam int FI = (gl < 8) ? LI : (LI ^ 1);
        logic [3:0]              lane_code;
        logic [2:0]              lane_ch;
        logic [aor_pkg::RES-1:0] lane_word;
        logic [13:0]             lane_pay;
        logic                    lane_en;

        if (gl < 8) begin : g_lo
            assign lane_code = lower_flat[4*FI +: 4];
            assign lane_ch = {1'b0, lane_code[2:1]};
        end else begin : g_up
            assign lane_code = upper_flat[4*FI +: 4];
            assign lane_ch = 3'h7 - {1'b0, lane_code[2:1]};
        end

        assign lane_word = {st_ff.held[lane_ch][aor_pkg::RES-1] ^ st_ff.btc,
                            st_ff.held[lane_ch][aor_pkg::RES-2:0]};
        assign lane_pay = two_wire ? (lane_code[0] ?
                                      {7'h00, lane_word[13:7]} :
                                      {7'h00, lane_word[6:0]})
                                   : lane_word;
        assign lane_en = !lane_code[aor_pkg::MAP_OFF_BIT] &&
                         (two_wire || !lane_code[0]);

        aor_lane_ser u_ser (
            .sys_clk    (sys_clk),
            .rst_n      (rst_n),
            .load       (st_ff.load),
            .word       (lane_pay),
            .nbits      (two_wire ? aor_pkg::BYTE_BITS : aor_pkg::WORD_BITS),
            .msb_first  (st_ff.msb_first),
            .enable     (lane_en),
            .ser_bit    (lane_bit[gl]),
            .ser_active (lane_act[gl]),
            .ser_frame  (lane_frm[gl])
        );
    end

    assign lanes = '{data: lane_bit, active: lane_act, frame: lane_frm};
endmodule
`default_nettype wire

// ===== sim/aor_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module aor_chk (
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire aor_pkg::aor_sample_t sample,
    input wire aor_pkg::aor_lane_t   lanes
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_wr_answer:
        assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_rd_answer:
        assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read data late");
    chk_b_hold:
        assert property (s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_hold:
        assert property (s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_w_refuse:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_ar_refuse:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    chk_lane_quiet:
        assert property ((lanes.data & ~lanes.active) == 16'h0)
        else $error("powered down lane toggles");
    chk_frame_live:
        assert property ((lanes.frame & ~lanes.active) == 16'h0)
        else $error("frame on powered down lane");
    chk_frame_cause:
        assert property ((|lanes.frame) |-> $past(sample.valid, 3))
        else $error("word without sample");
endmodule
bind aor_top aor_chk u_chk (
    .sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .sample, .lanes
);
`default_nettype wire

// ===== sim/aor_rx.sv
`timescale 1ns/1ps
`default_nettype none
module aor_rx (
    input wire logic               sys_clk,
    input wire logic               rst_n,
    input wire aor_pkg::aor_lane_t lanes,
    input wire logic [3:0]         sel,
    input wire logic [3:0]         nbits,
    output logic                   vld,
    output logic [13:0]            word
);
    logic [3:0]  cnt_ff;
    logic [13:0] sh_ff;
    logic [3:0]  idx;
    logic [13:0] acc;
    // Bits are stored in arrival order, first bit at position zero.
    always @(posedge sys_clk) begin
        vld <= 1'h0;
        idx = lanes.frame[sel] ? 4'h0 : cnt_ff;
        acc = lanes.frame[sel] ? 14'h0 : sh_ff;
        acc[idx] = lanes.data[sel];
        if (!rst_n) begin
            cnt_ff <= 4'h0;
        end else if (lanes.frame[sel] || cnt_ff != 4'h0) begin
            sh_ff <= acc;
            cnt_ff <= (idx + 4'h1 == nbits) ? 4'h0 : idx + 4'h1;
            vld <= (idx + 4'h1 == nbits);
            word <= acc;
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                 sys_clk;
    logic                 rst_n = 1'h0;
    logic                 awvalid = 1'h0;
    logic                 wvalid = 1'h0;
    logic                 bready = 1'h0;
    logic                 arvalid = 1'h0;
    logic                 rready = 1'h0;
    logic                 sync_pin = 1'h0;
    logic [11:0]          awaddr = 12'h0;
    logic [11:0]          araddr = 12'h0;
    logic [31:0]          wdata = 32'h0;
    logic                 btc = 1'h0;
    logic                 msbf = 1'h0;
    logic [3:0]           nb = 4'he;
    logic [3:0]           sel1 = 4'h8;
    int                   c0 = 0;
    int                   c1 = 4;
    int                   err_count = 0;
    int                   check_count = 0;
    aor_pkg::aor_sample_t smp = '0;
    aor_pkg::aor_lane_t   lanes;
    logic                 awready, wready, bvalid, arready, rvalid, v0, v1;
    logic [1:0]           bresp, rresp;
    logic [31:0]          rdata;
    logic [13:0]          w0, w1;
    logic [13:0]          rf [8] = '{default: '0};
    logic [33:0]          bq [$], q0 [$], q1 [$];

    aor_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sample(smp), .sync_pin(sync_pin),
        .lanes(lanes));
    aor_rx p0 (.sys_clk(sys_clk), .rst_n(rst_n), .lanes(lanes),
        .sel(4'h0), .nbits(nb), .vld(v0), .word(w0));
    aor_rx p1 (.sys_clk(sys_clk), .rst_n(rst_n), .lanes(lanes),
        .sel(sel1), .nbits(nb), .vld(v1), .word(w1));

    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [33:0] s, input logic [33:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    function automatic logic [33:0] pop(ref logic [33:0] q[$]);
        if (q.size() == 0) return 34'hx;
        return q.pop_front();
    endfunction

    function automatic logic [33:0] ex(input logic [13:0] c, input logic hi);
        logic [13:0] w;
        logic [13:0] r;
        w = c ^ {btc, 13'h0};
        if (nb == 4'h7) w = hi ? {7'h0, w[13:7]} : {7'h0, w[6:0]};
        r = 14'h0;
        for (int i = 0; i < 14; i++)
            if (i < nb) r[i] = msbf ? w[nb - 1 - i] : w[i];
        return {20'h0, r};
    endfunction

    function automatic logic [1:0] rsp(input logic [7:0] ix);
        return (ix == 8'hff) ? aor_pkg::RESP_SLVERR : aor_pkg::RESP_OKAY;
    endfunction

    task automatic wr(input logic [7:0] ix, input logic [15:0] d);
        logic aw;
        logic w;
        aw = 1'h1;
        w = 1'h1;
        bq.push_back({rsp(ix), 32'h0});
        awaddr <= {2'h0, ix, 2'h0};
        wdata <= {16'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (aw || w) begin
            @(posedge sys_clk);
            if (awready) aw = 1'h0;
            if (wready) w = 1'h0;
            awvalid <= aw;
            wvalid <= w;
        end
        while (!bvalid) @(posedge sys_clk);
        bready <= 1'h0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] ix, input logic [31:0] d);
        bq.push_back({rsp(ix), d});
        araddr <= {2'h0, ix, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        @(posedge sys_clk);
        while (!arready) @(posedge sys_clk);
        arvalid <= 1'h0;
        while (!rvalid) @(posedge sys_clk);
        rready <= 1'h0;
        @(posedge sys_clk);
    endtask

    task automatic snd(input logic p, input logic hold);
        logic [13:0] c;
        smp.valid <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            c = 14'($urandom);
            smp.code[i] <= c;
            if (!hold) rf[i] = c;
        end
        if (p && c0 >= 0) q0.push_back(ex(rf[c0], 1'h0));
        if (p && c1 >= 0) q1.push_back(ex(rf[c1], 1'h1));
        @(posedge sys_clk);
        smp.valid <= 1'h0;
        repeat (18) @(posedge sys_clk);
    endtask

    task automatic pulse();
        sync_pin <= 1'h1;
        repeat (3) @(posedge sys_clk);
        sync_pin <= 1'h0;
        repeat (8) @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        if (bvalid && bready) check({bresp, 32'h0}, pop(bq));
        if (rvalid && rready) check({rresp, rdata}, pop(bq));
        if (v0) check({20'h0, w0}, pop(q0));
        if (v1) check({20'h0, w1}, pop(q1));
    end

    initial begin
        #500000;
        err_count++;
        summarize();
    end

    initial begin
        void'($urandom(47630));
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'h1;
        rd(aor_pkg::IDX_RATE, 32'h0);
        rd(aor_pkg::IDX_FORMAT, 32'h0);
        rd(aor_pkg::IDX_HARD_SYNC, 32'h0);
        rd(aor_pkg::IDX_MAP_LO0, 32'h210);
        rd(aor_pkg::IDX_MAP_UP0, 32'h567);
        rd(8'hff, 32'h0);
        wr(8'hff, 16'h1);
        wr(aor_pkg::IDX_CTRL, 16'h5);
        wr(aor_pkg::IDX_HARD_SYNC, 16'h8000);
        pulse();
        rd(aor_pkg::IDX_STATUS, 32'haa);
        wr(aor_pkg::IDX_HARD_SYNC, 16'h0);
        pulse();
        rd(aor_pkg::IDX_STATUS, 32'h0);
        snd(1'h1, 1'h1);
        snd(1'h1, 1'h1);
        wr(aor_pkg::IDX_CTRL, 16'h0);
        for (int f = 0; f < 4; f++) begin
            btc = f[0];
            msbf = f[1];
            wr(aor_pkg::IDX_FORMAT, {12'h0, msbf, btc, 2'h0});
            snd(1'h1, 1'h0);
        end
        btc = 1'h0;
        msbf = 1'h0;
        wr(aor_pkg::IDX_FORMAT, 16'h0);
        for (int k = 0; k < 4; k++) begin
            c0 = k;
            c1 = 7 - k;
            wr(aor_pkg::IDX_MAP_LO0, {8'h21, 4'(2 * k)});
            wr(aor_pkg::IDX_MAP_UP0, {8'h5, 4'(2 * k), 4'h7});
            snd(1'h1, 1'h0);
        end
        c0 = -1;
        wr(aor_pkg::IDX_MAP_LO0, 16'h218);
        snd(1'h1, 1'h0);
        check({31'h0, lanes.active[8], lanes.active[1:0]}, 34'h4);
        c0 = 0;
        wr(aor_pkg::IDX_MAP_LO0, 16'h210);
        wr(aor_pkg::IDX_CTRL, 16'h2);
        nb = 4'h7;
        sel1 = 4'h9;
        snd(1'h1, 1'h0);
        snd(1'h1, 1'h0);
        wr(aor_pkg::IDX_CTRL, 16'h0);
        nb = 4'he;
        sel1 = 4'h8;
        for (int r = 0; r < 4; r++) begin
            wr(aor_pkg::IDX_RATE, 16'(r));
            pulse();
            for (int i = 0; i < 8; i++)
                snd((i % (1 << r)) == 0, 1'h0);
            check({2'h0, 32'(q0.size() + q1.size())}, 34'h0);
        end
        summarize();
    end
endmodule
`default_nettype wire
